// ==== verilog/sfrpx_sfr_ext.sv ====
`timescale 1ns/10ps
`include "sfrpx_cfg.svh"
module sfrpx_sfr_ext (
    input  wire logic          clk_sys,      // system clock
    input  wire logic          resetn,       // async reset, active low
    input  wire logic          sfr_wr,       // cpu write strobe
    input  wire logic          sfr_rd,       // cpu read strobe
    input  wire logic [7:0]    sfr_addr,     // cpu sfr address
    input  wire sfrpx_pkg::sfrpx_byte_t sfr_wdata, // write data
    output sfrpx_pkg::sfrpx_byte_t      sfr_rdata, // read data
    output logic               sfr_map_select, // mapped area active
    output sfrpx_pkg::sfrpx_page_t ccu_page,   // capture unit page
    output sfrpx_pkg::sfrpx_page_t module_page_select,   // generic module page
    output logic               ccu_sel,      // capture unit access
    output logic               wdt_sel,      // watchdog access
    output logic               mod_sel,      // generic module access
    input  wire sfrpx_pkg::sfrpx_byte_t ccu_rdata, // capture unit read
    input  wire sfrpx_pkg::sfrpx_byte_t wdt_rdata, // watchdog read
    input  wire sfrpx_pkg::sfrpx_byte_t mod_rdata, // generic read
    input  wire logic [7:0]    module_page_select_addr // generic page address
);
    import sfrpx_pkg::*;

    // ------------------------------------------------------------
    // reset and page registers
    // ------------------------------------------------------------
    logic rst_n;
    sfrpx_reset_sync u_rst (
        .clk_sys    (clk_sys),
        .resetn     (resetn),
        .rst_n_sync (rst_n)
    );

    sfrpx_page_if ccu_if ();
    sfrpx_page_if mod_if ();

    sfrpx_page_reg u_ccu_page (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .pif     (ccu_if.bank)
    );
    sfrpx_page_reg u_module_page_select (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .pif     (mod_if.bank)
    );

    // ------------------------------------------------------------
    // system control register with map select
    // ------------------------------------------------------------
    sfrpx_byte_t syscon_reg, syscon_next;
    logic        hit_syscon, hit_ccu_page, hit_module_page_select, hit_wdt;
    logic        map;

    function automatic logic in_wdt(input logic [7:0] a);
        in_wdt = a >= `SFRPX_WDT_LO_ADDR && a <= `SFRPX_WDT_HI_ADDR;
    endfunction

    always_comb begin
        map          = syscon_reg[`SFRPX_MAP_SEL_BIT];
        hit_syscon   = sfr_addr == `SFRPX_SYSCTL_ADDR;         // both areas
        hit_ccu_page = !map && sfr_addr == `SFRPX_CCU_PAGE_ADDR; // [R14]
        hit_module_page_select = map && sfr_addr == module_page_select_addr;
        hit_wdt      = map && in_wdt(sfr_addr);                // [R13] [R1]
        syscon_next  = syscon_reg;
        if (sfr_wr && hit_syscon) begin
            syscon_next = sfr_wdata;                           // [R1]
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            syscon_reg <= `SFRPX_SYSCON_RESET;
        end else begin
            syscon_reg <= syscon_next;
        end
    end

    // ------------------------------------------------------------
    // decode toward modules
    // ------------------------------------------------------------
    assign ccu_if.wr    = sfr_wr && hit_ccu_page;
    assign ccu_if.wdata = sfr_wdata;
    assign mod_if.wr    = sfr_wr && hit_module_page_select;
    assign mod_if.wdata = sfr_wdata;

    // 8-bit address plus map bit spans 512 register addresses
    assign ccu_sel  = !map && !hit_ccu_page && !hit_syscon;   // [R3] [R14]
    assign wdt_sel  = hit_wdt;                                 // [R13]
    assign mod_sel  = map && !hit_wdt && !hit_module_page_select && !hit_syscon;
    assign ccu_page = ccu_if.page;                             // [R16]
    assign module_page_select = mod_if.page;                             // [R16]
    assign sfr_map_select = map;

    // ------------------------------------------------------------
    // read data, registered
    // ------------------------------------------------------------
    sfrpx_byte_t rdata_reg, rdata_next;
    always_comb begin
        rdata_next = rdata_reg;
        if (sfr_rd) begin
            if (hit_syscon)        rdata_next = syscon_reg;
            else if (hit_ccu_page) rdata_next = ccu_if.rdata;  // [R6] [R11]
            else if (hit_module_page_select) rdata_next = mod_if.rdata;  // [R6] [R11]
            else if (hit_wdt)      rdata_next = wdt_rdata;
            else if (map)          rdata_next = mod_rdata;
            else                   rdata_next = ccu_rdata;
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end
    assign sfr_rdata = rdata_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    map_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R1]
        $fell(sfr_map_select) |-> $past(sfr_wr && hit_syscon))
        else $error("map select cleared without write");
    wdt_map_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R13]
        wdt_sel |-> sfr_map_select && in_wdt(sfr_addr))
        else $error("watchdog selected in standard area");
    ccu_std_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R14]
        ccu_if.wr |-> !sfr_map_select && sfr_addr == 8'hA3)
        else $error("capture page write outside standard area");
    page_rd_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R11]
        sfr_rd && hit_ccu_page |=> sfr_rdata == {5'h00, ccu_page})
        else $error("page readback wrong");
    page_rst_a: assert property (@(posedge clk_sys) // [R12]
        $rose(rst_n) |-> ccu_page == 3'h0 && module_page_select == 3'h0)
        else $error("page not zero after reset");
    map_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(sfr_map_select) ##[1:10] wdt_sel);
    ccu_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
        ccu_if.wr ##1 ccu_sel);
    mod_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
        mod_if.wr ##[1:10] mod_sel);
endmodule

// ==== pkg/sfrpx_cfg.svh ====
// Notes on behaviour
// [R1] map-select bit routes accesses to mapped area; only software writes change it. The code also clears it at reset.
// [R2] software changes map-select by read-modify-write, leaving other control bits alone.
// [R3] standard plus mapped areas give 512 register addresses.
// [R4] software programs a module's page before touching its paged registers.
// [R5] software sets both map-select and a valid page to reach a register.
// [R6] page field bits 2:0; manual write loads it, read returns active page.
// [R7] write-only slot number bits 5:4 pick storage slot 0 to 3.
// [R8] operation 0x: page loaded directly, slot number ignored.
// [R9] operation 10: page loaded and old page saved into chosen slot.
// [R10] operation 11: written page ignored, page restored from chosen slot.
// [R11] bit 3 reserved: reads zero, software writes zero.
// [R12] every page register resets to zero.
// [R13] watchdog registers reachable only with map-select set.
// [R14] capture unit registers and page register reachable with map-select clear.
// [R15] four storage slots per module, page-wide, unreadable, cleared at reset.
// [R16] paged module accesses decode using the module's active page.
`ifndef SFRPX_CFG_SVH
`define SFRPX_CFG_SVH
`define SFRPX_SYSCTL_ADDR   8'h8F
`define SFRPX_MAP_SEL_BIT   0
`define SFRPX_CCU_PAGE_ADDR 8'hA3
`define SFRPX_WDT_LO_ADDR   8'hBB
`define SFRPX_WDT_HI_ADDR   8'hBF
`define SFRPX_PAGE_MSB      2
`define SFRPX_SLOT_LSB      4
`define SFRPX_OPER_LSB      6
`define SFRPX_PAGE_RESET    8'h00
`define SFRPX_SYSCON_RESET  8'h00
`define SFRPX_NUM_SLOTS     4
`endif

// ==== pkg/sfrpx_pkg.sv ====
package sfrpx_pkg;
    typedef logic [7:0] sfrpx_byte_t;
    typedef logic [2:0] sfrpx_page_t;
    typedef logic [1:0] sfrpx_slot_t;
    typedef enum logic [2:0] {
        SFRPX_OP_MANUAL  = 3'h1,
        SFRPX_OP_SAVE    = 3'h2,
        SFRPX_OP_RESTORE = 3'h4
    } sfrpx_op_t;
    function automatic sfrpx_op_t sfrpx_decode_op(input logic [1:0] op);
        case (op)
            2'h2:    sfrpx_decode_op = SFRPX_OP_SAVE;
            2'h3:    sfrpx_decode_op = SFRPX_OP_RESTORE;
            default: sfrpx_decode_op = SFRPX_OP_MANUAL;
        endcase
    endfunction
endpackage

// ==== pkg/sfrpx_page_if.sv ====
`timescale 1ns/10ps
interface sfrpx_page_if;
    import sfrpx_pkg::*;
    logic        wr;
    sfrpx_byte_t wdata;
    sfrpx_byte_t rdata;
    sfrpx_page_t page;
    modport bank (input wr, input wdata, output rdata, output page);
    modport cpu  (output wr, output wdata, input rdata, input page);
endinterface

// ==== verilog/sfrpx_reset_sync.sv ====
`timescale 1ns/10ps
module sfrpx_reset_sync (
    input  wire logic clk_sys,  // system clock
    input  wire logic resetn,   // async reset in
    output logic      rst_n_sync // released reset
);
    logic [1:0] sync_reg;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sync_reg <= 2'h0;
        end else begin
            sync_reg <= {sync_reg[0], 1'b1};
        end
    end
    assign rst_n_sync = sync_reg[1];
endmodule

// ==== verilog/sfrpx_page_reg.sv ====
`timescale 1ns/10ps
`include "sfrpx_cfg.svh"
module sfrpx_page_reg (
    input  wire logic  clk_sys,  // system clock
    input  wire logic  rst_n,    // synchronised reset
    sfrpx_page_if.bank pif       // write port and state
);
    import sfrpx_pkg::*;
    sfrpx_page_t page_reg, page_next;
    sfrpx_page_t slot_reg  [`SFRPX_NUM_SLOTS];
    sfrpx_page_t slot_next [`SFRPX_NUM_SLOTS];
    sfrpx_slot_t sel;
    sfrpx_op_t   op;

    always_comb begin
        sel       = pif.wdata[`SFRPX_SLOT_LSB +: 2];                 // [R7]
        op        = sfrpx_decode_op(pif.wdata[`SFRPX_OPER_LSB +: 2]);
        page_next = page_reg;
        slot_next = slot_reg;
        if (pif.wr) begin
            case (op)
                SFRPX_OP_MANUAL:
                    page_next = pif.wdata[`SFRPX_PAGE_MSB:0];          // [R8]
                SFRPX_OP_SAVE: begin
                    page_next      = pif.wdata[`SFRPX_PAGE_MSB:0];     // [R9]
                    slot_next[sel] = page_reg;                         // [R9]
                end
                SFRPX_OP_RESTORE:
                    page_next = slot_reg[sel];                         // [R10]
                default:
                    page_next = page_reg;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            page_reg <= 3'h0;                                          // [R12]
            for (int i = 0; i < `SFRPX_NUM_SLOTS; i++) begin
                slot_reg[i] <= 3'h0;                                   // [R15]
            end
        end else begin
            page_reg <= page_next;
            slot_reg <= slot_next;
        end
    end

    assign pif.page  = page_reg;
    assign pif.rdata = {5'h00, page_reg};                              // [R6] [R11]

    save_slot_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R9]
        pif.wr && pif.wdata[7:6] == 2'h2 |=>
            slot_reg[$past(pif.wdata[5:4])] == $past(page_reg))
        else $error("save did not store old page");
    restore_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R10]
        pif.wr && pif.wdata[7:6] == 2'h3 |=>
            page_reg == $past(slot_reg[pif.wdata[5:4]]))
        else $error("restore did not load slot");
    manual_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R8]
        pif.wr && !pif.wdata[7] |=> page_reg == $past(pif.wdata[2:0]))
        else $error("manual page write failed");
    hold_page_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R6]
        !pif.wr |=> $stable(page_reg))
        else $error("page changed without write");
    save_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
        pif.wr && pif.wdata[7:6] == 2'h2 ##[1:20]
        pif.wr && pif.wdata[7:6] == 2'h3);
endmodule

// ==== verification/sfrpx_periph_model.sv ====
`timescale 1ns/10ps
// ----------------------------------------
// peripheral read data model
// ----------------------------------------
module sfrpx_periph_model (
    input  wire sfrpx_pkg::sfrpx_page_t ccu_page,  // capture unit page
    input  wire sfrpx_pkg::sfrpx_page_t module_page_select,  // generic module page
    output sfrpx_pkg::sfrpx_byte_t      ccu_rdata, // page-tagged data
    output sfrpx_pkg::sfrpx_byte_t      wdt_rdata, // fixed watchdog data
    output sfrpx_pkg::sfrpx_byte_t      mod_rdata  // page-tagged data
);
    import sfrpx_pkg::*;
    // data carries the active page so a stale page decode shows up
    assign ccu_rdata = {5'h11, ccu_page};
    assign wdt_rdata = 8'h5A;
    assign mod_rdata = {5'h1C, module_page_select};
endmodule

// ==== verification/tb_sfr_map_and_page_extension.sv ====
`timescale 1ns/10ps
module tb_sfr_map_and_page_extension;
    import sfrpx_pkg::*;
    localparam logic [7:0] MOD_ADDR = 8'hD0;
    logic        clk_sys, resetn, sfr_wr, sfr_rd;
    logic [7:0]  sfr_addr;
    sfrpx_byte_t sfr_wdata, sfr_rdata, ccu_rdata, wdt_rdata, mod_rdata;
    sfrpx_page_t ccu_page, module_page_select;
    logic        map_sel, ccu_sel, wdt_sel, mod_sel;
    int          n_fail, checked;
    logic [7:0]  row_wd [9] = '{8'h05, 8'h46, 8'h93, 8'hA1, 8'hF4,
                                8'hD0, 8'hE5, 8'h84, 8'hC0};
    logic [2:0]  row_pg [9] = '{3'h5, 3'h6, 3'h3, 3'h1, 3'h0,
                                3'h6, 3'h3, 3'h4, 3'h3};

    sfrpx_sfr_ext i_dut (.clk_sys(clk_sys), .resetn(resetn),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .sfr_map_select(map_sel), .ccu_page(ccu_page),
        .module_page_select(module_page_select), .ccu_sel(ccu_sel), .wdt_sel(wdt_sel),
        .mod_sel(mod_sel), .ccu_rdata(ccu_rdata), .wdt_rdata(wdt_rdata),
        .mod_rdata(mod_rdata), .module_page_select_addr(MOD_ADDR));
    sfrpx_periph_model i_peri (.ccu_page(ccu_page), .module_page_select(module_page_select),
        .ccu_rdata(ccu_rdata), .wdt_rdata(wdt_rdata),
        .mod_rdata(mod_rdata));

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // ----------------------------------------
    // bus tasks and checking
    // ----------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        sfr_wr    <= 1'b1;
        sfr_addr  <= a;
        sfr_wdata <= d;
        @(posedge clk_sys);
        sfr_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        sfr_rd   <= 1'b1;
        sfr_addr <= a;
        @(posedge clk_sys);
        sfr_rd <= 1'b0;
        #1;
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        #20000;
        n_fail++;
        wrap_up();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        resetn    = 1'b0;
        sfr_wr    = 1'b0;
        sfr_rd    = 1'b0;
        sfr_addr  = 8'h00;
        sfr_wdata = 8'h00;
        repeat (12) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rd(8'hA3);
        chk(sfr_rdata, 8'h00);
        chk({7'h0, map_sel}, 8'h00);
        for (int i = 0; i < 9; i++) begin
            wr(8'hA3, row_wd[i]);
            chk({5'h0, ccu_page}, {5'h0, row_pg[i]});
            rd(8'hA3);
            chk(sfr_rdata, {5'h0, row_pg[i]});
        end
        rd(8'h9A);
        chk({7'h0, ccu_sel}, 8'h01);
        chk(sfr_rdata, {5'h11, row_pg[8]});
        rd(8'hBB);
        chk({7'h0, wdt_sel}, 8'h00);
        wr(8'h8F, 8'h01);
        chk({7'h0, map_sel}, 8'h01);
        rd(8'h8F);
        chk(sfr_rdata, 8'h01);
        rd(8'hBB);
        chk({7'h0, wdt_sel}, 8'h01);
        chk(sfr_rdata, 8'h5A);
        rd(8'hA3);
        chk({7'h0, ccu_sel}, 8'h00);
        // generic module keeps slots of its own
        wr(MOD_ADDR, 8'h92);
        chk({5'h0, module_page_select}, 8'h02);
        chk({5'h0, ccu_page}, 8'h03);
        rd(MOD_ADDR);
        chk(sfr_rdata, 8'h02);
        rd(8'hE0);
        chk({7'h0, mod_sel}, 8'h01);
        chk(sfr_rdata, 8'hE2);
        wr(MOD_ADDR, 8'hD5);
        chk({5'h0, module_page_select}, 8'h00);
        repeat (20) @(posedge clk_sys);
        chk({7'h0, map_sel}, 8'h01);
        // second reset in mid-run clears slots too
        resetn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        chk({7'h0, map_sel}, 8'h00);
        chk({5'h0, ccu_page}, 8'h00);
        resetn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        wr(8'hA3, 8'h07);
        wr(8'hA3, 8'hD0);
        chk({5'h0, ccu_page}, 8'h00);
        wrap_up();
    end
endmodule
